// ===== rtl/isr_status.sv
`timescale 1ns/1ns
module isr_status (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // state inputs
  input wire isr_pkg::isr_parse_t parse_in,
  input wire isr_pkg::isr_timebase_t tb_in,
  input wire isr_pkg::isr_meas_t meas_in,
  input wire isr_pkg::isr_rcv_t rcv_in,
  // host command access
  input wire logic [3:0] reg_sel,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  // summaries and completion
  output logic std_summary_q,
  output logic ques_summary_q,
  output logic oper_summary_q,
  output logic rcv_summary_q,
  output logic op_complete_q
);
  logic [7:0] std_cond;
  logic [15:0] ques_cond;
  logic [15:0] oper_cond;
  logic [15:0] rcv_cond;
  logic [7:0] std_event_q;
  logic [7:0] std_enable_q;
  logic [15:0] ques_event_q;
  logic [15:0] ques_enable_q;
  logic [15:0] oper_event_q;
  logic [15:0] oper_enable_q;
  logic [15:0] rcv_event_q;
  logic [15:0] rcv_enable_q;
  logic std_sum;
  logic ques_sum;
  logic oper_sum;
  logic rcv_sum;
  logic pon_pulse;
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic op_complete_d;

  // ----------------------------------------
  // condition mapping
  // ----------------------------------------
  always_comb begin
    std_cond = 8'h00;
    std_cond[isr_pkg::STD_OP_COMPLETE] = parse_in.op_complete;
    std_cond[isr_pkg::STD_QUERY_ERR] = parse_in.query_err;
    std_cond[isr_pkg::STD_DEVICE_DEPENDENT_ERROR] =
      parse_in.device_dependent_error;
    std_cond[isr_pkg::STD_EXEC_ERR] = parse_in.exec_err;
    std_cond[isr_pkg::STD_CMD_ERR] = parse_in.cmd_err;
    std_cond[isr_pkg::STD_POWER_ON_FLAG] = pon_pulse;

    ques_cond = 16'h0000;
    ques_cond[isr_pkg::QUES_TIME_OF_DAY] = tb_in.time_not_decoded;
    ques_cond[isr_pkg::QUES_WARM_UP] = tb_in.warm_up;
    ques_cond[isr_pkg::QUES_TIME_UNLOCK] = tb_in.not_locked;
    ques_cond[isr_pkg::QUES_FREQ_STABILITY] = tb_in.not_stable;
    ques_cond[isr_pkg::QUES_ATOMIC_UNLOCK] =
      tb_in.atomic_timebase_unlocked;
    ques_cond[isr_pkg::QUES_PLL_UNLOCK] = tb_in.pll_unlocked;
    ques_cond[isr_pkg::QUES_CRYSTAL_RAIL] =
      tb_in.crystal_control_near_rail;
    ques_cond[isr_pkg::QUES_CONTROL_SAT] =
      tb_in.timebase_control_saturated;

    oper_cond = 16'h0000;
    oper_cond[isr_pkg::OPER_SETTING] = meas_in.settings_changing;
    oper_cond[isr_pkg::OPER_MEAS_FRONT] = meas_in.meas_front;
    oper_cond[isr_pkg::OPER_MEAS_REAR] = meas_in.meas_rear;
    // a tag on an input set for frequency is not a timing event
    oper_cond[isr_pkg::OPER_TAG_FRONT] =
      meas_in.timing_cfg_front & meas_in.tag_front;
    oper_cond[isr_pkg::OPER_TAG_REAR] =
      meas_in.timing_cfg_rear & meas_in.tag_rear;

    // receiver bits in order 0-7, 9, 11, 12
    rcv_cond = {3'h0, rcv_in.no_timing_pulses, rcv_in.almanac_incomplete,
      1'b0, rcv_in.position_suspect, 1'b0, rcv_in.leap_pending,
      rcv_in.no_position, rcv_in.survey, rcv_in.utc_unknown,
      rcv_in.no_satellites, rcv_in.antenna_short, rcv_in.antenna_open,
      rcv_in.time_not_set};
  end

  // ----------------------------------------
  // power-on flag source
  // ----------------------------------------
  isr_power_on u_pon (
    .mclk(mclk),
    .rst_b(rst_b),
    .pulse_q(pon_pulse)
  );

  // ----------------------------------------
  // status groups
  // ----------------------------------------
  isr_group #(.W(8), .USED(isr_pkg::STD_USED)) u_std (
    .mclk(mclk),
    .rst_b(rst_b),
    .cond_in(std_cond),
    .event_rd(rd_stb && reg_sel == isr_pkg::SEL_STD_EVENT),
    .enable_wr(wr_stb && reg_sel == isr_pkg::SEL_STD_ENABLE),
    .wdata(wdata[7:0]),
    .event_q(std_event_q),
    .enable_q(std_enable_q),
    .summary_q(std_sum)
  );

  isr_group #(.W(16), .USED(isr_pkg::QUES_USED)) u_ques (
    .mclk(mclk),
    .rst_b(rst_b),
    .cond_in(ques_cond),
    .event_rd(rd_stb && reg_sel == isr_pkg::SEL_QUES_EVENT),
    .enable_wr(wr_stb && reg_sel == isr_pkg::SEL_QUES_ENABLE),
    .wdata(wdata),
    .event_q(ques_event_q),
    .enable_q(ques_enable_q),
    .summary_q(ques_sum)
  );

  isr_group #(.W(16), .USED(isr_pkg::OPER_USED)) u_oper (
    .mclk(mclk),
    .rst_b(rst_b),
    .cond_in(oper_cond),
    .event_rd(rd_stb && reg_sel == isr_pkg::SEL_OPER_EVENT),
    .enable_wr(wr_stb && reg_sel == isr_pkg::SEL_OPER_ENABLE),
    .wdata(wdata),
    .event_q(oper_event_q),
    .enable_q(oper_enable_q),
    .summary_q(oper_sum)
  );

  isr_group #(.W(16), .USED(isr_pkg::RCV_USED)) u_rcv (
    .mclk(mclk),
    .rst_b(rst_b),
    .cond_in(rcv_cond),
    .event_rd(rd_stb && reg_sel == isr_pkg::SEL_RCV_EVENT),
    .enable_wr(wr_stb && reg_sel == isr_pkg::SEL_RCV_ENABLE),
    .wdata(wdata),
    .event_q(rcv_event_q),
    .enable_q(rcv_enable_q),
    .summary_q(rcv_sum)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = rd_stb;
    if (rd_stb) begin
      unique case (reg_sel)
        isr_pkg::SEL_STD_EVENT: rdata_d = {8'h00, std_event_q};
        isr_pkg::SEL_STD_ENABLE: rdata_d = {8'h00, std_enable_q};
        // conditions read live state, nothing else changes
        isr_pkg::SEL_QUES_COND:
          rdata_d = ques_cond & isr_pkg::QUES_USED;
        isr_pkg::SEL_QUES_EVENT: rdata_d = ques_event_q;
        isr_pkg::SEL_QUES_ENABLE: rdata_d = ques_enable_q;
        isr_pkg::SEL_OPER_COND:
          rdata_d = oper_cond & isr_pkg::OPER_USED;
        isr_pkg::SEL_OPER_EVENT: rdata_d = oper_event_q;
        isr_pkg::SEL_OPER_ENABLE: rdata_d = oper_enable_q;
        isr_pkg::SEL_RCV_COND:
          rdata_d = rcv_cond & isr_pkg::RCV_USED;
        isr_pkg::SEL_RCV_EVENT: rdata_d = rcv_event_q;
        isr_pkg::SEL_RCV_ENABLE: rdata_d = rcv_enable_q;
        default: rdata_d = 16'h0000;
      endcase
    end
    op_complete_d = !(meas_in.meas_front || meas_in.meas_rear);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      op_complete_q <= 1'b0;
      std_summary_q <= 1'b0;
      ques_summary_q <= 1'b0;
      oper_summary_q <= 1'b0;
      rcv_summary_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      op_complete_q <= op_complete_d;
      std_summary_q <= std_sum;
      ques_summary_q <= ques_sum;
      oper_summary_q <= oper_sum;
      rcv_summary_q <= rcv_sum;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_opc;
    @(posedge mclk) disable iff (!rst_b)
      (meas_in.meas_front || meas_in.meas_rear) |=> !op_complete_q;
  endproperty
  a_opc: assert property (p_opc)
    else $error("completion reported during measurement");

  property p_tag_gate;
    @(posedge mclk) disable iff (!rst_b)
      (meas_in.tag_front && !meas_in.timing_cfg_front &&
       !oper_event_q[isr_pkg::OPER_TAG_FRONT] && !rd_stb)
      |=> !oper_event_q[isr_pkg::OPER_TAG_FRONT] || $past(rd_stb);
  endproperty
  a_tag_gate: assert property (p_tag_gate)
    else $error("front tag event without timing setup");

  property p_tod;
    @(posedge mclk) disable iff (!rst_b)
      tb_in.time_not_decoded |=> ques_event_q[isr_pkg::QUES_TIME_OF_DAY];
  endproperty
  a_tod: assert property (p_tod)
    else $error("time of day bit not set");

  property p_cond_read;
    @(posedge mclk) disable iff (!rst_b)
      (rd_stb && reg_sel == isr_pkg::SEL_OPER_COND)
      |=> rdata_q == ($past(oper_cond) & isr_pkg::OPER_USED) && rvalid_q;
  endproperty
  a_cond_read: assert property (p_cond_read)
    else $error("condition read wrong");

  property p_std_summary;
    @(posedge mclk) disable iff (!rst_b)
      (std_enable_q == 8'h00) [*3] |-> !std_summary_q;
  endproperty
  a_std_summary: assert property (p_std_summary)
    else $error("standard summary high with empty mask");

  property p_pon;
    @(posedge mclk) disable iff (!rst_b)
      $rose(rst_b) |-> ##2 std_event_q[isr_pkg::STD_POWER_ON_FLAG];
  endproperty
  a_pon: assert property (p_pon)
    else $error("power-on flag missing after reset");

  // ----------------------------------------
  // per-flag checks, set wins over any read
  // ----------------------------------------
  property p_opc_flag;
    @(posedge mclk) disable iff (!rst_b)
      parse_in.op_complete |=> std_event_q[isr_pkg::STD_OP_COMPLETE];
  endproperty
  a_opc_flag: assert property (p_opc_flag)
    else $error("operation complete flag not latched");

  property p_query_err;
    @(posedge mclk) disable iff (!rst_b)
      parse_in.query_err |=> std_event_q[isr_pkg::STD_QUERY_ERR];
  endproperty
  a_query_err: assert property (p_query_err)
    else $error("query error flag not latched");

  property p_dev_err;
    @(posedge mclk) disable iff (!rst_b)
      parse_in.device_dependent_error
      |=> std_event_q[isr_pkg::STD_DEVICE_DEPENDENT_ERROR];
  endproperty
  a_dev_err: assert property (p_dev_err)
    else $error("device dependent error flag not latched");

  property p_exec_err;
    @(posedge mclk) disable iff (!rst_b)
      parse_in.exec_err |=> std_event_q[isr_pkg::STD_EXEC_ERR];
  endproperty
  a_exec_err: assert property (p_exec_err)
    else $error("execution error flag not latched");

  property p_cmd_err;
    @(posedge mclk) disable iff (!rst_b)
      parse_in.cmd_err |=> std_event_q[isr_pkg::STD_CMD_ERR];
  endproperty
  a_cmd_err: assert property (p_cmd_err)
    else $error("command error flag not latched");

  property p_warm_up;
    @(posedge mclk) disable iff (!rst_b)
      tb_in.warm_up |=> ques_event_q[isr_pkg::QUES_WARM_UP];
  endproperty
  a_warm_up: assert property (p_warm_up)
    else $error("warm-up flag not latched");

  property p_atomic;
    @(posedge mclk) disable iff (!rst_b)
      tb_in.atomic_timebase_unlocked
      |=> ques_event_q[isr_pkg::QUES_ATOMIC_UNLOCK];
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("atomic timebase unlock flag not latched");

  property p_setting;
    @(posedge mclk) disable iff (!rst_b)
      meas_in.settings_changing |=> oper_event_q[isr_pkg::OPER_SETTING];
  endproperty
  a_setting: assert property (p_setting)
    else $error("settings change flag not latched");

  // ----------------------------------------
  // host access checks
  // ----------------------------------------
  sequence s_ques_ev_rd;
    rd_stb && reg_sel == isr_pkg::SEL_QUES_EVENT;
  endsequence

  sequence s_oper_ev_rd;
    rd_stb && reg_sel == isr_pkg::SEL_OPER_EVENT;
  endsequence

  sequence s_rcv_ev_rd;
    rd_stb && reg_sel == isr_pkg::SEL_RCV_EVENT;
  endsequence

  // answer carries the value held before the clear
  property p_ques_ev_rd;
    @(posedge mclk) disable iff (!rst_b)
      s_ques_ev_rd |=> rvalid_q && rdata_q == $past(ques_event_q);
  endproperty
  a_ques_ev_rd: assert property (p_ques_ev_rd)
    else $error("questionable event read wrong");

  property p_oper_ev_rd;
    @(posedge mclk) disable iff (!rst_b)
      s_oper_ev_rd |=> rvalid_q && rdata_q == $past(oper_event_q);
  endproperty
  a_oper_ev_rd: assert property (p_oper_ev_rd)
    else $error("operational event read wrong");

  property p_rcv_ev_rd;
    @(posedge mclk) disable iff (!rst_b)
      s_rcv_ev_rd |=> rvalid_q && rdata_q == $past(rcv_event_q);
  endproperty
  a_rcv_ev_rd: assert property (p_rcv_ev_rd)
    else $error("receiver event read wrong");

  property p_ques_en_wr;
    @(posedge mclk) disable iff (!rst_b)
      (wr_stb && reg_sel == isr_pkg::SEL_QUES_ENABLE)
      |=> ques_enable_q == ($past(wdata) & isr_pkg::QUES_USED);
  endproperty
  a_ques_en_wr: assert property (p_ques_en_wr)
    else $error("questionable enable write wrong");

  property p_ques_summary;
    @(posedge mclk) disable iff (!rst_b)
      (ques_enable_q == 16'h0000) [*3] |-> !ques_summary_q;
  endproperty
  a_ques_summary: assert property (p_ques_summary)
    else $error("questionable summary high with empty mask");
endmodule

// ===== rtl/isr_pkg.sv
// Function
// - standard event bits: 0,2,3,4,5,7 used
// - bad parameter sets exec error; syntax command
// - power cycle sets power-on flag
// - standard event enable mask gates summary
// - questionable bit 0 until time decoded
// - questionable bits 1,2,5 follow timebase state
// - questionable bits 10 to 13 unlock/rail flags
// - questionable condition, event, enable readable
// - operational bit 1 while settings change
// - operational bits 4,5 measurement in progress
// - completion query true when bits 4,5 clear
// - bits 6,7 only timing-configured tag recorded
// - operational condition, event, enable readable
// - receiver bits 0 to 3 fault flags
// - receiver bits 4 to 7 status flags
// - receiver bits 9,11,12 status flags
// - receiver condition, event, enable readable
// - condition follows input, read never alters
// - event sticky, cleared by read, resets again
// - summary is OR of enabled events
package isr_pkg;

  // ----------------------------------------
  // register select codes
  // ----------------------------------------
  localparam logic [3:0] SEL_STD_EVENT = 4'h0;
  localparam logic [3:0] SEL_STD_ENABLE = 4'h1;
  localparam logic [3:0] SEL_QUES_COND = 4'h2;
  localparam logic [3:0] SEL_QUES_EVENT = 4'h3;
  localparam logic [3:0] SEL_QUES_ENABLE = 4'h4;
  localparam logic [3:0] SEL_OPER_COND = 4'h5;
  localparam logic [3:0] SEL_OPER_EVENT = 4'h6;
  localparam logic [3:0] SEL_OPER_ENABLE = 4'h7;
  localparam logic [3:0] SEL_RCV_COND = 4'h8;
  localparam logic [3:0] SEL_RCV_EVENT = 4'h9;
  localparam logic [3:0] SEL_RCV_ENABLE = 4'hA;

  // ----------------------------------------
  // standard event bit positions
  // ----------------------------------------
  localparam int STD_OP_COMPLETE = 0;
  localparam int STD_QUERY_ERR = 2;
  localparam int STD_DEVICE_DEPENDENT_ERROR = 3;
  localparam int STD_EXEC_ERR = 4;
  localparam int STD_CMD_ERR = 5;
  localparam int STD_POWER_ON_FLAG = 7;
  localparam logic [7:0] STD_USED = 8'hBD;

  // ----------------------------------------
  // questionable bit positions
  // ----------------------------------------
  localparam int QUES_TIME_OF_DAY = 0;
  localparam int QUES_WARM_UP = 1;
  localparam int QUES_TIME_UNLOCK = 2;
  localparam int QUES_FREQ_STABILITY = 5;
  localparam int QUES_ATOMIC_UNLOCK = 10;
  localparam int QUES_PLL_UNLOCK = 11;
  localparam int QUES_CRYSTAL_RAIL = 12;
  localparam int QUES_CONTROL_SAT = 13;
  localparam logic [15:0] QUES_USED = 16'h3C27;

  // ----------------------------------------
  // operational bit positions
  // ----------------------------------------
  localparam int OPER_SETTING = 1;
  localparam int OPER_MEAS_FRONT = 4;
  localparam int OPER_MEAS_REAR = 5;
  localparam int OPER_TAG_FRONT = 6;
  localparam int OPER_TAG_REAR = 7;
  localparam logic [15:0] OPER_USED = 16'h00F2;

  // ----------------------------------------
  // receiver bit mask, bits 0-7, 9, 11, 12
  // ----------------------------------------
  localparam logic [15:0] RCV_USED = 16'h1AFF;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_EVENT = 16'h0000;
  localparam logic [15:0] RST_ENABLE = 16'h0000;

  typedef struct packed {
    logic op_complete;
    logic query_err;
    logic device_dependent_error;
    logic exec_err;
    logic cmd_err;
  } isr_parse_t;

  typedef struct packed {
    logic time_not_decoded;
    logic warm_up;
    logic not_locked;
    logic not_stable;
    logic atomic_timebase_unlocked;
    logic pll_unlocked;
    logic crystal_control_near_rail;
    logic timebase_control_saturated;
  } isr_timebase_t;

  typedef struct packed {
    logic settings_changing;
    logic meas_front;
    logic meas_rear;
    logic timing_cfg_front;
    logic timing_cfg_rear;
    logic tag_front;
    logic tag_rear;
  } isr_meas_t;

  typedef struct packed {
    logic time_not_set;
    logic antenna_open;
    logic antenna_short;
    logic no_satellites;
    logic utc_unknown;
    logic survey;
    logic no_position;
    logic leap_pending;
    logic position_suspect;
    logic almanac_incomplete;
    logic no_timing_pulses;
  } isr_rcv_t;

endpackage

// ===== rtl/isr_group.sv
`timescale 1ns/1ns
module isr_group #(
  parameter int W = 16,
  parameter logic [W-1:0] USED = '1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // condition input
  input wire logic [W-1:0] cond_in,
  // host access
  input wire logic event_rd,
  input wire logic enable_wr,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] event_q,
  output logic [W-1:0] enable_q,
  output logic summary_q
);
  logic [W-1:0] event_d;
  logic [W-1:0] enable_d;
  logic summary_d;

  // ----------------------------------------
  // sticky events, set wins over read clear
  // ----------------------------------------
  always_comb begin
    event_d = event_q;
    if (event_rd) begin
      event_d = '0;
    end
    event_d = (event_d | cond_in) & USED;
    enable_d = enable_q;
    if (enable_wr) begin
      enable_d = wdata & USED;
    end
    // summary lags events by one cycle to stay registered
    summary_d = |(event_q & enable_q);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      event_q <= W'(isr_pkg::RST_EVENT);
      enable_q <= W'(isr_pkg::RST_ENABLE);
      summary_q <= 1'b0;
    end else begin
      event_q <= event_d;
      enable_q <= enable_d;
      summary_q <= summary_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_grp_sticky;
    @(posedge mclk) disable iff (!rst_b)
      (|event_q && !event_rd)
      |=> ((event_q & $past(event_q)) == $past(event_q));
  endproperty
  a_grp_sticky: assert property (p_grp_sticky)
    else $error("event bit dropped without read");

  property p_grp_reset_again;
    @(posedge mclk) disable iff (!rst_b)
      event_rd |=> (event_q == ($past(cond_in) & USED));
  endproperty
  a_grp_reset_again: assert property (p_grp_reset_again)
    else $error("event after read not equal to condition");

  property p_grp_summary;
    @(posedge mclk) disable iff (!rst_b)
      ##1 summary_q == |($past(event_q) & $past(enable_q));
  endproperty
  a_grp_summary: assert property (p_grp_summary)
    else $error("summary not OR of enabled events");

  property p_grp_unused;
    @(posedge mclk) disable iff (!rst_b)
      ((event_q | enable_q) & ~USED) == '0;
  endproperty
  a_grp_unused: assert property (p_grp_unused)
    else $error("unassigned bit set");
endmodule

// ===== rtl/isr_power_on.sv
`timescale 1ns/1ns
module isr_power_on (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // one pulse on the first cycle after reset release
  output logic pulse_q
);
  logic armed_q;
  logic armed_d;
  logic pulse_d;

  always_comb begin
    armed_d = 1'b1;
    pulse_d = !armed_q;
  end

  // reset stands for the power cycle of the unit
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      pulse_q <= pulse_d;
    end
  end
endmodule

// ===== verif/isr_host.sv
`timescale 1ns/1ns
module isr_host (
  // clock
  input wire logic mclk,
  // request side
  output logic [3:0] reg_sel,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] wdata,
  // answer side
  input wire logic [15:0] rdata_q,
  input wire logic rvalid_q
);
  initial begin
    reg_sel = 4'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wdata = 16'h0000;
  end

  // idle qualifiers flip so a stale value never passes for a live one
  task automatic release_bus();
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    reg_sel = ~reg_sel;
    wdata = ~wdata;
  endtask

  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    reg_sel = sel;
    wdata = d;
    wr_stb = 1'b1;
    @(posedge mclk);
    #1;
    release_bus();
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [3:0] sel, output logic [15:0] d,
                    output bit ok);
    int n;
    ok = 1'b0;
    d = 16'h0000;
    reg_sel = sel;
    rd_stb = 1'b1;
    @(posedge mclk);
    #1;
    release_bus();
    for (n = 0; n < 4; n++) begin
      if (!ok && rvalid_q === 1'b1) begin
        d = rdata_q;
        ok = 1'b1;
      end
      if (!ok) begin
        @(posedge mclk);
        #1;
      end
    end
    // one idle edge keeps back-to-back calls from double driving
    @(posedge mclk);
    #1;
  endtask
endmodule

// ===== verif/isr_status_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("unexpected at %0t got %h expected %h", $time, (a), (b)); \
  end \
end

module isr_status_tb;
  logic mclk;
  logic rst_b;
  isr_pkg::isr_parse_t parse_in;
  isr_pkg::isr_timebase_t tb_in;
  isr_pkg::isr_meas_t meas_in;
  isr_pkg::isr_rcv_t rcv_in;
  logic [3:0] reg_sel;
  logic rd_stb;
  logic wr_stb;
  logic [15:0] wdata;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [3:0] sum;
  logic op_complete_q;
  logic [15:0] lfsr;
  int num_errors = 0;
  int comparisons = 0;

  isr_status i_dut (.mclk(mclk), .rst_b(rst_b), .parse_in(parse_in),
    .tb_in(tb_in), .meas_in(meas_in), .rcv_in(rcv_in),
    .reg_sel(reg_sel), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .std_summary_q(sum[3]),
    .ques_summary_q(sum[2]), .oper_summary_q(sum[1]),
    .rcv_summary_q(sum[0]), .op_complete_q(op_complete_q));

  isr_host i_host (.mclk(mclk), .reg_sel(reg_sel), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wdata(wdata), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] e_std(input isr_pkg::isr_parse_t p);
    e_std = {2'b00, p.cmd_err, p.exec_err, p.device_dependent_error,
             p.query_err, 1'b0, p.op_complete};
  endfunction

  function automatic logic [15:0] e_ques(input isr_pkg::isr_timebase_t t);
    e_ques = 16'h0000;
    e_ques[0] = t.time_not_decoded;
    e_ques[1] = t.warm_up;
    e_ques[2] = t.not_locked;
    e_ques[5] = t.not_stable;
    e_ques[10] = t.atomic_timebase_unlocked;
    e_ques[11] = t.pll_unlocked;
    e_ques[12] = t.crystal_control_near_rail;
    e_ques[13] = t.timebase_control_saturated;
  endfunction

  function automatic logic [15:0] e_oper(input isr_pkg::isr_meas_t m);
    e_oper = 16'h0000;
    e_oper[1] = m.settings_changing;
    e_oper[4] = m.meas_front;
    e_oper[5] = m.meas_rear;
    e_oper[6] = m.timing_cfg_front & m.tag_front;
    e_oper[7] = m.timing_cfg_rear & m.tag_rear;
  endfunction

  function automatic logic [15:0] e_rcv(input isr_pkg::isr_rcv_t r);
    e_rcv = 16'h0000;
    e_rcv[0] = r.time_not_set;
    e_rcv[1] = r.antenna_open;
    e_rcv[2] = r.antenna_short;
    e_rcv[3] = r.no_satellites;
    e_rcv[4] = r.utc_unknown;
    e_rcv[5] = r.survey;
    e_rcv[6] = r.no_position;
    e_rcv[7] = r.leap_pending;
    e_rcv[9] = r.position_suspect;
    e_rcv[11] = r.almanac_incomplete;
    e_rcv[12] = r.no_timing_pulses;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    i_host.rd(sel, d, ok);
    if (!ok) begin
      num_errors++;
      print_verdict();
    end else begin
      `CHK(d, exp)
    end
  endtask

  // ----------------------------------------
  // one pass: masks, hold, release, drain
  // ----------------------------------------
  task automatic run(input isr_pkg::isr_timebase_t t,
    input isr_pkg::isr_meas_t m, input isr_pkg::isr_rcv_t r,
    input isr_pkg::isr_parse_t p, input logic [15:0] qm,
    input logic [15:0] om, input logic [15:0] rm, input logic [7:0] sm);
    logic [15:0] eq;
    logic [15:0] eo;
    logic [15:0] er;
    logic [15:0] es;
    eq = e_ques(t);
    eo = e_oper(m);
    er = e_rcv(r);
    es = {8'h00, e_std(p)};
    i_host.wr(4'h4, qm);
    i_host.wr(4'h7, om);
    i_host.wr(4'hA, rm);
    i_host.wr(4'h1, {8'hFF, sm});
    rd_chk(4'h4, qm & 16'h3C27);
    rd_chk(4'h7, om & 16'h00F2);
    rd_chk(4'hA, rm & 16'h1AFF);
    rd_chk(4'h1, {8'h00, sm & 8'hBD});
    tb_in = t;
    meas_in = m;
    rcv_in = r;
    parse_in = p;
    cyc(1);
    parse_in = '0;
    cyc(2);
    `CHK(op_complete_q, ~(m.meas_front | m.meas_rear))
    rd_chk(4'h2, eq);
    rd_chk(4'h2, eq);
    rd_chk(4'h5, eo);
    rd_chk(4'h8, er);
    rd_chk(4'h3, eq);
    rd_chk(4'h3, eq);
    tb_in = '0;
    meas_in = '0;
    rcv_in = '0;
    cyc(3);
    `CHK(sum, {|(es & sm), |(eq & qm), |(eo & om), |(er & rm)})
    rd_chk(4'h3, eq);
    rd_chk(4'h3, 16'h0000);
    rd_chk(4'h6, eo);
    rd_chk(4'h6, 16'h0000);
    rd_chk(4'h9, er);
    rd_chk(4'h9, 16'h0000);
    rd_chk(4'h0, es);
    rd_chk(4'h0, 16'h0000);
    cyc(3);
    `CHK(sum, 4'h0)
    `CHK(op_complete_q, 1'b1)
  endtask

  initial begin
    rst_b = 1'b0;
    parse_in = '0;
    tb_in = '0;
    meas_in = '0;
    rcv_in = '0;
    lfsr = 16'hEACD;
    repeat (12) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    cyc(4);
    rd_chk(4'h0, 16'h0080);
    rd_chk(4'h0, 16'h0000);
    i_host.wr(4'h3, 16'hFFFF);
    rd_chk(4'h3, 16'h0000);
    rd_chk(4'hB, 16'h0000);
    // saturated inputs: empty masks must keep summaries low, then full masks
    run('1, '1, '1, '1, 16'h0000, 16'h0000, 16'h0000, 8'h00);
    run('1, '1, '1, '1, 16'hFFFF, 16'hFFFF, 16'hFFFF, 8'hFF);
    repeat (24) begin
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] c;
      lfsr = nxt(lfsr);
      a = lfsr;
      lfsr = nxt(lfsr);
      b = lfsr;
      lfsr = nxt(lfsr);
      c = lfsr;
      run(isr_pkg::isr_timebase_t'(a[7:0]), isr_pkg::isr_meas_t'(a[14:8]),
          isr_pkg::isr_rcv_t'(b[10:0]), isr_pkg::isr_parse_t'(b[15:11]),
          c, ~c, {c[7:0], c[15:8]}, a[15:8] ^ c[7:0]);
    end
    print_verdict();
  end
endmodule
